// file: common/mitu_pkg.sv
package mitu_pkg;

  // one instruction cycle is this many system clocks
  localparam int unsigned CLKS_PER_CYCLE = 4;
  localparam logic [1:0]  PHASE_LAST     = 2'h3;
  localparam logic [1:0]  PHASE_FIRST    = 2'h0;

  localparam int unsigned PC_W       = 13;
  localparam int unsigned STACK_D    = 8;
  localparam int unsigned SP_W       = 3;
  localparam logic [12:0] PC_RESET   = 13'h0000;
  localparam logic [2:0]  SP_RESET   = 3'h0;
  localparam logic [7:0]  ACC_RESET  = 8'h00;
  localparam logic [15:0] TBL_RESET  = 16'h0000;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_TRANSFER_M2A,
    OP_TRANSFER_A2M,
    OP_TRANSFER_I2A,
    OP_ADD,
    OP_ADC,
    OP_SUB,
    OP_SBC,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_BITWISE_INVERT,
    OP_PLUS_ONE,
    OP_MINUS_ONE,
    OP_RIGHT_ROTATE,
    OP_LEFT_ROTATE,
    OP_RIGHT_ROTATE_VIA_CARRY,
    OP_LEFT_ROTATE_VIA_CARRY,
    OP_SKIP_IF_ZERO,
    OP_SKIP_IF_NONZERO,
    OP_JUMP,
    OP_CALL,
    OP_SUBROUTINE_EXIT,
    OP_INTERRUPT_EXIT,
    OP_TABLE_READ
  } mitu_op_type;

  typedef struct packed {
    mitu_op_type op;
    logic        use_imm;       // second operand is the immediate
    logic        to_mem;        // result goes to data memory
    logic        dest_pc_low;   // data memory target is the pc low byte
    logic [7:0]  imm;
    logic [7:0]  mem_data;      // operand read from data memory
    logic [12:0] target;        // branch address
  } mitu_instr_type;

  typedef struct packed {
    logic z;
    logic c;
    logic ac;
    logic ov;
  } mitu_flags_type;

  localparam mitu_flags_type FLAGS_RESET = '{z: 1'b0, c: 1'b0,
                                             ac: 1'b0, ov: 1'b0};

endpackage : mitu_pkg

// file: core/mitu_core.sv
`timescale 1ns/1ps

module mitu_core (
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  // decoded instruction at o_prog_addr_r, and raw program word
  input  wire mitu_pkg::mitu_instr_type i_instr,
  input  wire logic [15:0]             i_prog_word,
  // program memory address
  output logic [12:0]                  o_prog_addr_r,
  output logic [15:0]                  o_tbl_word_r,
  // data memory write
  output logic                         o_mem_wr_r,
  output logic [7:0]                   o_mem_wdata_r,
  // core state
  output logic [7:0]                   o_acc_r,
  output mitu_pkg::mitu_flags_type     o_flags_r,
  output logic [1:0]                   o_phase_r,
  output logic                         o_exec_r,
  output logic                         o_int_exit_r
);

  typedef enum logic {ST_EXEC, ST_FLUSH} mitu_state_type;

  // two-cycle decode, used by the sequencer and its checks
  function automatic logic mitu_two_cycle(input mitu_pkg::mitu_op_type op);
    mitu_two_cycle = (op == mitu_pkg::OP_JUMP) ||
                     (op == mitu_pkg::OP_CALL) ||
                     (op == mitu_pkg::OP_SUBROUTINE_EXIT) ||
                     (op == mitu_pkg::OP_INTERRUPT_EXIT) ||
                     (op == mitu_pkg::OP_TABLE_READ);
  endfunction : mitu_two_cycle

  mitu_state_type           state_r;
  mitu_state_type           state_nxt;
  logic [12:0]              pc_r;
  logic [12:0]              pc_nxt;
  logic [2:0]               sp_r;
  logic [12:0]              stack_r [mitu_pkg::STACK_D];
  logic                     tbl_pending_r;
  logic                     exec_fire;
  logic [7:0]               src;
  logic [7:0]               alu_res;
  mitu_pkg::mitu_flags_type flags_nxt;
  logic                     res_valid;
  logic                     skip_taken;
  logic                     pc_low_wr;
  logic [8:0]               wide;
  logic [4:0]               nib;
  logic [12:0]              pc_inc;

  assign exec_fire = (state_r == ST_EXEC) &&
                     (o_phase_r == mitu_pkg::PHASE_LAST);
  assign src       = i_instr.use_imm ? i_instr.imm : i_instr.mem_data;
  assign pc_inc    = pc_r + 13'h0001;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_phase_r <= mitu_pkg::PHASE_FIRST;
    end else begin
      o_phase_r <= o_phase_r + 2'h1;
    end
  end

  // result and flag datapath
  always_comb begin
    alu_res   = o_acc_r;
    flags_nxt = o_flags_r;
    res_valid = 1'b0;
    wide      = 9'h000;
    nib       = 5'h00;
    unique case (i_instr.op)
      mitu_pkg::OP_TRANSFER_M2A,
      mitu_pkg::OP_TRANSFER_I2A: begin
        alu_res   = src;
        res_valid = 1'b1;
      end
      mitu_pkg::OP_TRANSFER_A2M: begin
        alu_res   = o_acc_r;
        res_valid = 1'b1;
      end
      mitu_pkg::OP_ADD, mitu_pkg::OP_ADC: begin
        wide = {1'b0, o_acc_r} + {1'b0, src} +
               {8'h00, (i_instr.op == mitu_pkg::OP_ADC) & o_flags_r.c};
        nib  = {1'b0, o_acc_r[3:0]} + {1'b0, src[3:0]} +
               {4'h0, (i_instr.op == mitu_pkg::OP_ADC) & o_flags_r.c};
        alu_res      = wide[7:0];
        flags_nxt.c  = wide[8];
        flags_nxt.ac = nib[4];
        flags_nxt.ov = (o_acc_r[7] == src[7]) && (wide[7] != o_acc_r[7]);
        flags_nxt.z  = (wide[7:0] == 8'h00);
        res_valid    = 1'b1;
      end
      mitu_pkg::OP_SUB, mitu_pkg::OP_SBC: begin
        // carry holds the borrow, so sbc chains multi-byte subtraction
        wide = {1'b0, o_acc_r} - {1'b0, src} -
               {8'h00, (i_instr.op == mitu_pkg::OP_SBC) & o_flags_r.c};
        nib  = {1'b0, o_acc_r[3:0]} - {1'b0, src[3:0]} -
               {4'h0, (i_instr.op == mitu_pkg::OP_SBC) & o_flags_r.c};
        alu_res      = wide[7:0];
        flags_nxt.c  = wide[8];
        flags_nxt.ac = nib[4];
        flags_nxt.ov = (o_acc_r[7] != src[7]) && (wide[7] != o_acc_r[7]);
        flags_nxt.z  = (wide[7:0] == 8'h00);
        res_valid    = 1'b1;
      end
      mitu_pkg::OP_AND, mitu_pkg::OP_OR, mitu_pkg::OP_XOR,
      mitu_pkg::OP_BITWISE_INVERT: begin
        if (i_instr.op == mitu_pkg::OP_AND) begin
          alu_res = o_acc_r & src;
        end else if (i_instr.op == mitu_pkg::OP_OR) begin
          alu_res = o_acc_r | src;
        end else if (i_instr.op == mitu_pkg::OP_XOR) begin
          alu_res = o_acc_r ^ src;
        end else begin
          alu_res = ~src;
        end
        flags_nxt.z = (alu_res == 8'h00);
        res_valid   = 1'b1;
      end
      mitu_pkg::OP_PLUS_ONE, mitu_pkg::OP_MINUS_ONE: begin
        alu_res = (i_instr.op == mitu_pkg::OP_PLUS_ONE) ?
                  src + 8'h01 : src - 8'h01;
        flags_nxt.z = (alu_res == 8'h00);
        res_valid   = 1'b1;
      end
      mitu_pkg::OP_RIGHT_ROTATE: begin
        alu_res   = {src[0], src[7:1]};
        res_valid = 1'b1;
      end
      mitu_pkg::OP_LEFT_ROTATE: begin
        alu_res   = {src[6:0], src[7]};
        res_valid = 1'b1;
      end
      mitu_pkg::OP_RIGHT_ROTATE_VIA_CARRY: begin
        alu_res     = {o_flags_r.c, src[7:1]};
        flags_nxt.c = src[0];
        res_valid   = 1'b1;
      end
      mitu_pkg::OP_LEFT_ROTATE_VIA_CARRY: begin
        alu_res     = {src[6:0], o_flags_r.c};
        flags_nxt.c = src[7];
        res_valid   = 1'b1;
      end
      default: begin
        alu_res = o_acc_r;
      end
    endcase
  end

  assign skip_taken = exec_fire &&
    (((i_instr.op == mitu_pkg::OP_SKIP_IF_ZERO) && (src == 8'h00)) ||
     ((i_instr.op == mitu_pkg::OP_SKIP_IF_NONZERO) && (src != 8'h00)));
  assign pc_low_wr  = exec_fire && res_valid && i_instr.to_mem &&
                      i_instr.dest_pc_low;

  // program counter and sequencing
  always_comb begin
    pc_nxt    = pc_r;
    state_nxt = state_r;
    if (exec_fire) begin
      pc_nxt    = pc_inc;
      state_nxt = ST_EXEC;
      if (pc_low_wr) begin
        pc_nxt    = {pc_r[12:8], alu_res};
        state_nxt = ST_FLUSH;
      end else if (skip_taken) begin
        pc_nxt    = pc_r + 13'h0002;
        state_nxt = ST_FLUSH;
      end else if (mitu_two_cycle(i_instr.op)) begin
        state_nxt = ST_FLUSH;
        unique case (i_instr.op)
          mitu_pkg::OP_JUMP, mitu_pkg::OP_CALL: pc_nxt = i_instr.target;
          mitu_pkg::OP_SUBROUTINE_EXIT,
          mitu_pkg::OP_INTERRUPT_EXIT: pc_nxt = stack_r[sp_r - 3'h1];
          default: pc_nxt = pc_inc;
        endcase
      end
    end else if ((state_r == ST_FLUSH) &&
                 (o_phase_r == mitu_pkg::PHASE_LAST)) begin
      state_nxt = ST_EXEC;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= ST_EXEC;
      pc_r    <= mitu_pkg::PC_RESET;
    end else begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
    end
  end

  // fetch address; a table read borrows it for the flush cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_prog_addr_r <= mitu_pkg::PC_RESET;
      tbl_pending_r <= 1'b0;
      o_tbl_word_r  <= mitu_pkg::TBL_RESET;
    end else if (exec_fire && (i_instr.op == mitu_pkg::OP_TABLE_READ)) begin
      o_prog_addr_r <= {pc_r[12:8], o_acc_r};
      tbl_pending_r <= 1'b1;
    end else if ((state_r == ST_FLUSH) &&
                 (o_phase_r == mitu_pkg::PHASE_LAST)) begin
      if (tbl_pending_r) begin
        o_tbl_word_r <= i_prog_word;
      end
      tbl_pending_r <= 1'b0;
      o_prog_addr_r <= pc_r;
    end else if (!tbl_pending_r) begin
      // table address must stand until the word is captured
      o_prog_addr_r <= pc_nxt;
    end
  end

  // return stack, wraps after eight levels
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sp_r <= mitu_pkg::SP_RESET;
    end else if (exec_fire && (i_instr.op == mitu_pkg::OP_CALL)) begin
      stack_r[sp_r] <= pc_inc;
      sp_r          <= sp_r + 3'h1;
    end else if (exec_fire &&
                 ((i_instr.op == mitu_pkg::OP_SUBROUTINE_EXIT) ||
                  (i_instr.op == mitu_pkg::OP_INTERRUPT_EXIT))) begin
      sp_r <= sp_r - 3'h1;
    end
  end

  // accumulator and flags
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_acc_r   <= mitu_pkg::ACC_RESET;
      o_flags_r <= mitu_pkg::FLAGS_RESET;
    end else if (exec_fire && res_valid) begin
      if (!i_instr.to_mem && (i_instr.op != mitu_pkg::OP_TRANSFER_A2M)) begin
        o_acc_r <= alu_res;
      end
      o_flags_r <= flags_nxt;
    end
  end

  // data memory write; a pc low byte target is written to pc_r, not to memory
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_mem_wr_r    <= 1'b0;
      o_mem_wdata_r <= mitu_pkg::ACC_RESET;
    end else begin
      o_mem_wr_r <= exec_fire && res_valid && !i_instr.dest_pc_low &&
                    (i_instr.to_mem ||
                     (i_instr.op == mitu_pkg::OP_TRANSFER_A2M));
      if (exec_fire && res_valid) begin
        o_mem_wdata_r <= alu_res;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_exec_r     <= 1'b0;
      o_int_exit_r <= 1'b0;
    end else begin
      o_exec_r     <= exec_fire;
      o_int_exit_r <= exec_fire &&
                      (i_instr.op == mitu_pkg::OP_INTERRUPT_EXIT);
    end
  end

  property p_phase_wrap;
    @(posedge i_clk) disable iff (i_sys_rst)
      (o_phase_r == mitu_pkg::PHASE_LAST) |=>
        (o_phase_r == mitu_pkg::PHASE_FIRST) ##3
        (o_phase_r == mitu_pkg::PHASE_LAST);
  endproperty
  a_phase_wrap: assert property (p_phase_wrap)
    else $error("instruction cycle is not four clocks");

  property p_two_cycle;
    @(posedge i_clk) disable iff (i_sys_rst)
      (exec_fire && mitu_two_cycle(i_instr.op)) |=>
        (!exec_fire) [*7] ##1 exec_fire;
  endproperty
  a_two_cycle: assert property (p_two_cycle)
    else $error("two-cycle instruction did not take eight clocks");

  property p_pc_low;
    @(posedge i_clk) disable iff (i_sys_rst)
      pc_low_wr |=> (pc_r[7:0] == $past(alu_res)) && (state_r == ST_FLUSH);
  endproperty
  a_pc_low: assert property (p_pc_low)
    else $error("pc low byte write did not jump with extra cycle");

  property p_skip;
    @(posedge i_clk) disable iff (i_sys_rst)
      skip_taken |=> (pc_r == $past(pc_r) + 13'h0002) ##7 exec_fire;
  endproperty
  a_skip: assert property (p_skip)
    else $error("taken skip did not advance by two after one extra cycle");

  property p_plain_one;
    @(posedge i_clk) disable iff (i_sys_rst)
      (exec_fire && !skip_taken && !pc_low_wr &&
       !mitu_two_cycle(i_instr.op)) |-> ##4 exec_fire;
  endproperty
  a_plain_one: assert property (p_plain_one)
    else $error("single-cycle instruction stalled");

  property p_imm_move;
    @(posedge i_clk) disable iff (i_sys_rst)
      (exec_fire && (i_instr.op == mitu_pkg::OP_TRANSFER_I2A) &&
       i_instr.use_imm && !i_instr.to_mem) |=>
        (o_acc_r == $past(i_instr.imm));
  endproperty
  a_imm_move: assert property (p_imm_move)
    else $error("immediate move did not load the accumulator");

  property p_add_carry;
    @(posedge i_clk) disable iff (i_sys_rst)
      (exec_fire && (i_instr.op == mitu_pkg::OP_ADD)) |=>
        (o_flags_r.c ==
         (({1'b0, $past(o_acc_r)} + {1'b0, $past(src)}) > 9'h0ff));
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add carry wrong");

  property p_inc_acc;
    @(posedge i_clk) disable iff (i_sys_rst)
      (exec_fire && (i_instr.op == mitu_pkg::OP_PLUS_ONE) &&
       !i_instr.to_mem) |=>
        (o_acc_r == $past(src) + 8'h01) && $stable(o_flags_r.c);
  endproperty
  a_inc_acc: assert property (p_inc_acc)
    else $error("increment to accumulator wrong");

  property p_logic_zero;
    @(posedge i_clk) disable iff (i_sys_rst)
      (exec_fire && !i_instr.to_mem &&
       ((i_instr.op == mitu_pkg::OP_AND) || (i_instr.op == mitu_pkg::OP_XOR) ||
        (i_instr.op == mitu_pkg::OP_OR))) |=>
        (o_flags_r.z == (o_acc_r == 8'h00));
  endproperty
  a_logic_zero: assert property (p_logic_zero)
    else $error("logic zero flag wrong");

  property p_mem_dest;
    @(posedge i_clk) disable iff (i_sys_rst)
      (exec_fire && res_valid && i_instr.to_mem && !i_instr.dest_pc_low) |=>
        o_mem_wr_r && $stable(o_acc_r);
  endproperty
  a_mem_dest: assert property (p_mem_dest)
    else $error("memory destination touched the accumulator");

  property p_rrc;
    @(posedge i_clk) disable iff (i_sys_rst)
      (exec_fire && (i_instr.op == mitu_pkg::OP_RIGHT_ROTATE_VIA_CARRY) &&
       !i_instr.to_mem) |=>
        (o_flags_r.c == $past(src[0])) && (o_acc_r[7] == $past(o_flags_r.c));
  endproperty
  a_rrc: assert property (p_rrc)
    else $error("rotate through carry wrong");

  property p_rot_flags;
    @(posedge i_clk) disable iff (i_sys_rst)
      (exec_fire && ((i_instr.op == mitu_pkg::OP_RIGHT_ROTATE) ||
                     (i_instr.op == mitu_pkg::OP_LEFT_ROTATE))) |=>
        $stable(o_flags_r);
  endproperty
  a_rot_flags: assert property (p_rot_flags)
    else $error("plain rotate changed flags");

endmodule : mitu_core

// file: testbench/mitu_core_bench.sv
`timescale 1ns/1ps
module mitu_core_bench;
  logic                     i_clk;
  logic                     i_sys_rst;
  mitu_pkg::mitu_instr_type i_instr;
  logic [15:0]              i_prog_word;
  logic [12:0]              o_prog_addr_r;
  logic [15:0]              o_tbl_word_r;
  logic                     o_mem_wr_r;
  logic [7:0]               o_mem_wdata_r;
  logic [7:0]               o_acc_r;
  mitu_pkg::mitu_flags_type o_flags_r;
  logic [1:0]               o_phase_r;
  logic                     o_exec_r;
  logic                     o_int_exit_r;
  mitu_pkg::mitu_instr_type rom [128];
  logic [7:0]               exp_acc [32];
  logic [3:0]               exp_flg [32];
  logic [7:0]               exp_dat [32];
  logic                     exp_wr  [32];
  int                       nrow;
  int                       miscompares;
  int                       compares;

  mitu_core mitu_core_i (
    .i_clk         (i_clk),
    .i_sys_rst     (i_sys_rst),
    .i_instr       (i_instr),
    .i_prog_word   (i_prog_word),
    .o_prog_addr_r (o_prog_addr_r),
    .o_tbl_word_r  (o_tbl_word_r),
    .o_mem_wr_r    (o_mem_wr_r),
    .o_mem_wdata_r (o_mem_wdata_r),
    .o_acc_r       (o_acc_r),
    .o_flags_r     (o_flags_r),
    .o_phase_r     (o_phase_r),
    .o_exec_r      (o_exec_r),
    .o_int_exit_r  (o_int_exit_r)
  );

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // program memory model: word contents encode their own address
  always @(negedge i_clk) begin
    i_instr     <= rom[o_prog_addr_r[6:0]];
    i_prog_word <= {3'h5, o_prog_addr_r};
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic put(input logic [6:0] a, input mitu_pkg::mitu_op_type op,
                     input logic [7:0] v, input logic ui, input logic tm,
                     input logic [12:0] tgt);
    rom[a]          = '0;
    rom[a].op       = op;
    rom[a].imm      = v;
    rom[a].mem_data = v;
    rom[a].use_imm  = ui;
    rom[a].to_mem   = tm;
    rom[a].target   = tgt;
  endtask : put

  // hold reset 12 clocks over the program already in rom; this task loads nothing
  task automatic start;
    @(negedge i_clk);
    i_sys_rst = 1'b1;
    repeat (12) @(negedge i_clk);
    i_sys_rst = 1'b0;
  endtask : start

  task automatic blank;
    for (int k = 0; k < 128; k++) put(k[6:0], mitu_pkg::OP_NOP, 8'h00,
                                      1'b0, 1'b0, 13'h0000);
  endtask : blank

  // wait for the next execution; gap is counted in system clocks
  task automatic ex(input int g, input logic [12:0] a, input logic w);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_exec_r !== 1'b1 && n < 40);
    if (o_exec_r !== 1'b1) begin
      miscompares++;
      $display("unexpected execution: expected pulse, seen none");
      summarize();
    end
    check("cycle gap", 16'(n), 16'(g));
    check("phase", 16'(o_phase_r), 16'(mitu_pkg::PHASE_FIRST));
    check("fetch address", 16'(o_prog_addr_r), 16'(a));
    check("memory write", 16'(o_mem_wr_r), 16'(w));
  endtask : ex

  task automatic t_reset;
    blank();
    start();
    check("reset address", 16'(o_prog_addr_r), 16'h0000);
    check("reset acc", 16'(o_acc_r), 16'h0000);
    check("reset flags", 16'(o_flags_r), 16'h0000);
    ex(4, 13'h0001, 1'b0);
    for (int k = 2; k < 6; k++) ex(4, 13'(k), 1'b0);
    $display("test reset_and_sequencing done");
  endtask : t_reset

  task automatic t_branch;
    blank();
    put(7'h00, mitu_pkg::OP_TRANSFER_I2A, 8'h37, 1'b1, 1'b0, 13'h0);
    put(7'h01, mitu_pkg::OP_JUMP, 8'h00, 1'b0, 1'b0, 13'h0010);
    put(7'h02, mitu_pkg::OP_TRANSFER_I2A, 8'hee, 1'b1, 1'b0, 13'h0);
    put(7'h10, mitu_pkg::OP_CALL, 8'h00, 1'b0, 1'b0, 13'h0020);
    put(7'h11, mitu_pkg::OP_CALL, 8'h00, 1'b0, 1'b0, 13'h0030);
    put(7'h30, mitu_pkg::OP_INTERRUPT_EXIT, 8'h00, 1'b0, 1'b0, 13'h0);
    put(7'h20, mitu_pkg::OP_TABLE_READ, 8'h00, 1'b0, 1'b0, 13'h0);
    put(7'h21, mitu_pkg::OP_SUBROUTINE_EXIT, 8'h00, 1'b0, 1'b0, 13'h0);
    start();
    ex(4, 13'h0001, 1'b0);
    ex(4, 13'h0010, 1'b0);
    ex(8, 13'h0020, 1'b0);
    ex(8, 13'h0037, 1'b0);
    ex(8, 13'h0011, 1'b0);
    check("table word", o_tbl_word_r, 16'ha037);
    check("int exit idle", 16'(o_int_exit_r), 16'h0000);
    ex(8, 13'h0030, 1'b0);
    ex(8, 13'h0012, 1'b0);
    check("int exit pulse", 16'(o_int_exit_r), 16'h0001);
    check("discarded fetch", 16'(o_acc_r), 16'h0037);
    $display("test two_cycle_branches done");
  endtask : t_branch

  task automatic t_pcl;
    blank();
    put(7'h00, mitu_pkg::OP_TRANSFER_I2A, 8'h40, 1'b1, 1'b0, 13'h0);
    put(7'h01, mitu_pkg::OP_TRANSFER_A2M, 8'h00, 1'b0, 1'b1, 13'h0);
    rom[1].dest_pc_low = 1'b1;
    put(7'h02, mitu_pkg::OP_TRANSFER_I2A, 8'hee, 1'b1, 1'b0, 13'h0);
    put(7'h40, mitu_pkg::OP_TRANSFER_I2A, 8'h55, 1'b1, 1'b0, 13'h0);
    put(7'h41, mitu_pkg::OP_TRANSFER_A2M, 8'h00, 1'b0, 1'b1, 13'h0);
    start();
    ex(4, 13'h0001, 1'b0);
    ex(4, 13'h0040, 1'b0);
    ex(8, 13'h0041, 1'b0);
    ex(4, 13'h0042, 1'b1);
    check("write data", 16'(o_mem_wdata_r), 16'h0055);
    check("acc kept", 16'(o_acc_r), 16'h0055);
    $display("test pc_low_write done");
  endtask : t_pcl

  task automatic t_skip;
    blank();
    put(7'h00, mitu_pkg::OP_SKIP_IF_ZERO, 8'h00, 1'b0, 1'b0, 13'h0);
    put(7'h01, mitu_pkg::OP_TRANSFER_I2A, 8'hee, 1'b1, 1'b0, 13'h0);
    put(7'h02, mitu_pkg::OP_SKIP_IF_ZERO, 8'h05, 1'b0, 1'b0, 13'h0);
    put(7'h03, mitu_pkg::OP_SKIP_IF_NONZERO, 8'h05, 1'b0, 1'b0, 13'h0);
    put(7'h04, mitu_pkg::OP_TRANSFER_I2A, 8'hee, 1'b1, 1'b0, 13'h0);
    put(7'h05, mitu_pkg::OP_SKIP_IF_NONZERO, 8'h00, 1'b0, 1'b0, 13'h0);
    start();
    ex(4, 13'h0002, 1'b0);
    ex(8, 13'h0003, 1'b0);
    ex(4, 13'h0005, 1'b0);
    ex(8, 13'h0006, 1'b0);
    ex(4, 13'h0007, 1'b0);
    check("skipped acc", 16'(o_acc_r), 16'h0000);
    $display("test conditional_skip done");
  endtask : t_skip

  // flags column is {z, c, ac, ov}
  task automatic row(input mitu_pkg::mitu_op_type op, input logic [7:0] v,
                     input logic ui, input logic tm, input logic [7:0] ea,
                     input logic [3:0] ef, input logic [7:0] ed);
    put(nrow[6:0], op, v, ui, tm, 13'h0);
    exp_acc[nrow] = ea;
    exp_flg[nrow] = ef;
    exp_dat[nrow] = ed;
    exp_wr[nrow]  = tm;
    nrow++;
  endtask : row

  task automatic t_alu;
    blank();
    nrow = 0;
    row(mitu_pkg::OP_TRANSFER_I2A, 8'hff, 1'b1, 1'b0, 8'hff, 4'h0, 8'h0);
    row(mitu_pkg::OP_ADD, 8'h01, 1'b1, 1'b0, 8'h00, 4'he, 8'h0);
    row(mitu_pkg::OP_ADC, 8'h00, 1'b1, 1'b0, 8'h01, 4'h0, 8'h0);
    row(mitu_pkg::OP_SUB, 8'h02, 1'b1, 1'b0, 8'hff, 4'h6, 8'h0);
    row(mitu_pkg::OP_SBC, 8'h00, 1'b1, 1'b0, 8'hfe, 4'h0, 8'h0);
    row(mitu_pkg::OP_AND, 8'h01, 1'b1, 1'b0, 8'h00, 4'h8, 8'h0);
    row(mitu_pkg::OP_OR, 8'h0f, 1'b1, 1'b0, 8'h0f, 4'h0, 8'h0);
    row(mitu_pkg::OP_XOR, 8'h0e, 1'b1, 1'b0, 8'h01, 4'h0, 8'h0);
    row(mitu_pkg::OP_BITWISE_INVERT, 8'hff, 1'b0, 1'b0, 8'h00, 4'h8, 8'h0);
    row(mitu_pkg::OP_PLUS_ONE, 8'h7f, 1'b0, 1'b0, 8'h80, 4'h0, 8'h0);
    row(mitu_pkg::OP_MINUS_ONE, 8'h01, 1'b0, 1'b0, 8'h00, 4'h8, 8'h0);
    row(mitu_pkg::OP_MINUS_ONE, 8'h00, 1'b0, 1'b1, 8'h00, 4'h0, 8'hff);
    row(mitu_pkg::OP_TRANSFER_M2A, 8'h81, 1'b0, 1'b0, 8'h81, 4'h0, 8'h0);
    row(mitu_pkg::OP_RIGHT_ROTATE, 8'h81, 1'b0, 1'b0, 8'hc0, 4'h0, 8'h0);
    row(mitu_pkg::OP_LEFT_ROTATE, 8'h81, 1'b0, 1'b0, 8'h03, 4'h0, 8'h0);
    row(mitu_pkg::OP_RIGHT_ROTATE_VIA_CARRY, 8'h01, 1'b0, 1'b0, 8'h00,
        4'h4, 8'h0);
    row(mitu_pkg::OP_LEFT_ROTATE_VIA_CARRY, 8'h80, 1'b0, 1'b0, 8'h01,
        4'h4, 8'h0);
    row(mitu_pkg::OP_TRANSFER_I2A, 8'h7f, 1'b1, 1'b0, 8'h7f, 4'h4, 8'h0);
    row(mitu_pkg::OP_ADD, 8'h01, 1'b1, 1'b0, 8'h80, 4'h3, 8'h0);
    row(mitu_pkg::OP_RIGHT_ROTATE, 8'h00, 1'b0, 1'b0, 8'h00, 4'h3, 8'h0);
    row(mitu_pkg::OP_TRANSFER_A2M, 8'h00, 1'b0, 1'b1, 8'h00, 4'h3, 8'h00);
    start();
    for (int k = 0; k < nrow; k++) begin
      ex(4, 13'(k + 1), exp_wr[k]);
      check("acc", 16'(o_acc_r), 16'(exp_acc[k]));
      check("flags", 16'(o_flags_r), 16'(exp_flg[k]));
      if (exp_wr[k]) begin
        check("wdata", 16'(o_mem_wdata_r), 16'(exp_dat[k]));
      end
    end
    $display("test data_path_and_flags done");
  endtask : t_alu

  initial begin
    i_sys_rst   = 1'b1;
    i_instr     = '0;
    i_prog_word = 16'h0000;
    miscompares = 0;
    compares    = 0;
    t_reset();
    t_branch();
    t_pcl();
    t_skip();
    t_alu();
    summarize();
  end
endmodule : mitu_core_bench
